// File: tb_watchdog_timer_unit.sv
// Purpose: Self-checking bench for wdtu_top
// Assumes: CNT_WIDTH 8 shortens the period
// Notes: Reads checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_timer_unit
    import wdtu_pkg::*;
;
    localparam int PER = 256 - 'hf0;
    logic        clk = 0;
    logic        rst = 1;
    logic        sel = 0;
    logic        wr = 0;
    logic        stop = 0;
    logic        dph = 0;
    logic        saw = 0;
    logic [1:0]  tr = 0;
    logic [31:0] addr = 0;
    logic [31:0] wd = 0;
    logic [31:0] lf = 32'd68872;
    logic [31:0] rv;
    logic [31:0] rdat;
    logic [31:0] exq[$];
    logic        rdy;
    logic        resp;
    logic        irq;
    logic        creq;
    logic        cause;
    int          fails = 0;
    int          comparisons = 0;
    int          n;
    always #2.5 clk = ~clk;
    wdtu_top #(.CNT_WIDTH(8)) i_dut (.REF_CLK(clk), .RST(rst), .HSEL(sel), .HADDR(addr),
        .HTRANS(tr), .HWRITE(wr), .HSIZE(3'b010), .HREADY(rdy), .HWDATA(wd), .HRDATA(rdat),
        .HREADYOUT(rdy), .HRESP(resp), .CLK_STOPPED(stop), .IRQ(irq),
        .CHIP_RESET_REQ(creq), .WDOG_RESET_CAUSE(cause));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic report_and_stop;
        $display("counts: %0d compared, %0d failed", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        n = 0;
        sel <= 1;
        tr <= HTRANS_NONSEQ;
        wr <= w;
        addr <= {26'h0, a};
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        sel <= 0;
        tr <= 2'b00;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 40);
        cmp({31'h0, resp}, 32'h0);
        if (n >= 20) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exq.push_back(e);
        bus(0, a, 32'h0);
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? irq : (s == 1 ? creq : cause);
    endfunction
    // Flags are sampled at the falling edge, settled
    task automatic fl(input int s, input logic e);
        @(negedge clk);
        cmp({31'h0, sig(s)}, {31'h0, e});
        @(posedge clk);
    endtask
    task automatic wait_hi(input int s, output int k);
        k = 0;
        while (sig(s) !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k >= 300) begin
            fails++;
            report_and_stop();
        end
        @(posedge clk);
    endtask
    // Read data is taken at the edge that ends its data phase
    always @(posedge clk) begin
        if (dph)
            cmp(rdat, exq.pop_front());
        dph <= sel & tr[1] & ~wr & rdy & ~rst;
    end
    always @(negedge clk) begin
        if (creq === 1'b1)
            saw = 1;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(OFS_MODE, 32'h0);
        rd(OFS_RELOAD, RELOAD_RESET);
        rd(OFS_COUNT, COUNT_RESET);
        rd(OFS_EN_VIEW, 32'h0);
        rd(OFS_ST_VIEW, 32'h0);
        lf = nxt(lf);
        bus(1, 6'h2c, lf);
        rd(6'h2c, 32'h0);
        bus(1, OFS_RELOAD, lf);
        rd(OFS_RELOAD, RELOAD_RESET);
        $display("test registers done");
        bus(1, OFS_MODE, 32'h1);
        rd(OFS_MODE, 32'h1);
        bus(1, OFS_RELOAD, UNLOCK_FIRST);
        bus(1, OFS_RELOAD, UNLOCK_SECOND);
        rv = {lf[31:8], 8'hf0};
        bus(1, OFS_RELOAD, rv);
        rd(OFS_RELOAD, rv);
        rd(OFS_MODE, 32'h3);
        bus(1, OFS_EN_SET, 32'h1);
        rd(OFS_EN_VIEW, 32'h1);
        bus(1, OFS_TRIG, 32'hfffffffe);
        repeat (40) @(posedge clk);
        fl(0, 0);
        bus(1, OFS_TRIG, 32'h1);
        stop <= 1;
        repeat (40) @(posedge clk);
        rd(OFS_COUNT, {24'h0, rv[7:0]});
        fl(0, 0);
        stop <= 0;
        wait_hi(0, n);
        cmp(n >= PER && n <= PER + 6, 1);
        rd(OFS_ST_VIEW, 32'h1);
        bus(1, OFS_TRIG, 32'h1);
        repeat (40) @(posedge clk);
        fl(0, 1);
        fl(1, 0);
        bus(1, OFS_ST_CLR, 32'h1);
        @(posedge clk);
        fl(0, 0);
        wait_hi(0, n);
        cmp(n <= PER + 6, 1);
        bus(1, OFS_EN_CLR, 32'h1);
        @(posedge clk);
        fl(0, 0);
        rd(OFS_EN_VIEW, 32'h0);
        $display("test debug irq done");
        bus(1, OFS_ST_CLR, 32'h1);
        bus(1, OFS_ST_SET, 32'h1);
        rd(OFS_ST_VIEW, 32'h1);
        fl(0, 0);
        bus(1, OFS_TRIG, 32'h1);
        bus(1, OFS_MODE, 32'h0);
        bus(1, OFS_TRIG, 32'h1);
        bus(1, OFS_MODE, 32'h1);
        bus(1, OFS_TRIG, 32'h1);
        rd(OFS_MODE, 32'he);
        saw = 0;
        repeat (6) begin
            bus(1, OFS_TRIG, 32'h1);
            repeat (6) @(posedge clk);
        end
        cmp(saw, 0);
        wait_hi(1, n);
        cmp(n <= PER + 6, 1);
        repeat (6) @(posedge clk);
        fl(1, 0);
        rst <= 1;
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(OFS_MODE, 32'h0);
        rd(OFS_RELOAD, RELOAD_RESET);
        fl(2, 1);
        rd(OFS_RSTCAUSE, 32'h1);
        bus(1, OFS_RSTCAUSE, 32'h1);
        fl(2, 0);
        $display("test chip reset done");
        report_and_stop();
    end
endmodule // tb_watchdog_timer_unit
`default_nettype wire

// File: wdtu_asserts.sv
// Purpose: Port checks for wdtu_top
// Assumes: Zero-wait slave, one clock
// Notes: Sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module wdtu_asserts
    import wdtu_pkg::*;
#(
    parameter int CNT_WIDTH = 32
) (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        IRQ,
    input wire logic        CHIP_RESET_REQ,
    input wire logic        WDOG_RESET_CAUSE
);
    logic       rd_q;
    logic       wr_q;
    logic [5:0] wa_q;
    wire        take = HSEL & HREADY & HTRANS[1];
    wire        clr = wr_q & HWDATA[0] & (wa_q == OFS_ST_CLR | wa_q == OFS_EN_CLR);
    always_ff @(posedge REF_CLK) begin
        rd_q <= ~RST & take & ~HWRITE;
        wr_q <= ~RST & take & HWRITE;
        wa_q <= HADDR[5:0];
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    property p_ready; HREADYOUT && !HRESP; endproperty
    a_ready: assert property (p_ready) else $error("slave stalled or erred");
    property p_idle; !rd_q |-> HRDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside data phase");
    property p_pulse; $rose(CHIP_RESET_REQ) |-> CHIP_RESET_REQ [*4] ##1 !CHIP_RESET_REQ;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset request length");
    property p_cause; CHIP_RESET_REQ |-> ##[0:4] WDOG_RESET_CAUSE; endproperty
    a_cause: assert property (p_cause) else $error("reset cause not set");
    property p_clr; clr |-> ##[1:2] !IRQ; endproperty
    a_clr: assert property (p_clr) else $error("irq stays after clear");
    property p_hold; IRQ && !clr && !$past(clr) |=> IRQ; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped by itself");
    property p_rise; $rose(IRQ) |-> !CHIP_RESET_REQ; endproperty
    a_rise: assert property (p_rise) else $error("irq with reset request");
    property p_rst;
        disable iff (1'b0) RST |=> !IRQ && !CHIP_RESET_REQ && HRDATA == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    c_irq: cover property ($rose(IRQ));
    c_req: cover property ($rose(CHIP_RESET_REQ));
    c_clr: cover property (clr);
endmodule // wdtu_asserts
bind wdtu_top wdtu_asserts #(.CNT_WIDTH(CNT_WIDTH)) i_chk (.*);
`default_nettype wire

// File: wdtu_counter.sv
// Purpose: 32-bit watchdog counting element
// Assumes: Clock gating stall arrives as a level
// Notes:   Wrap of all-ones marks the overflow
`timescale 1ns/1ps
`default_nettype none
module wdtu_counter #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             run,
    input  wire logic             stall,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic             adv;
    // R11 stall holds count
    assign adv     = run && !stall;
    // R23 load on trigger
    // R2 increment each cycle
    assign count_d = load ? load_value : (adv ? count_q + WIDTH'(1) : count_q);
    // R23 wrap detection
    assign wrap    = adv && !load && (count_q == {WIDTH{1'b1}});
    assign count   = count_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= WIDTH'(0);
        end else begin
            count_q <= count_d;
        end
    end
endmodule // wdtu_counter
`default_nettype wire

// File: wdtu_pkg.sv
// Purpose: Constants for the watchdog timer unit
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses
package wdtu_pkg;
    localparam logic [5:0]  OFS_MODE      = 6'h00;
    localparam logic [5:0]  OFS_RELOAD    = 6'h04;
    localparam logic [5:0]  OFS_COUNT     = 6'h08;
    localparam logic [5:0]  OFS_TRIG      = 6'h0c;
    localparam logic [5:0]  OFS_ST_SET    = 6'h10;
    localparam logic [5:0]  OFS_ST_CLR    = 6'h14;
    localparam logic [5:0]  OFS_EN_VIEW   = 6'h18;
    localparam logic [5:0]  OFS_ST_VIEW   = 6'h1c;
    localparam logic [5:0]  OFS_EN_SET    = 6'h20;
    localparam logic [5:0]  OFS_EN_CLR    = 6'h24;
    localparam logic [5:0]  OFS_RSTCAUSE  = 6'h28;
    localparam logic [31:0] RELOAD_RESET  = 32'h00ffffff;
    localparam logic [31:0] COUNT_RESET   = 32'h00000000;
    localparam logic [31:0] UNLOCK_FIRST  = 32'haaaaaaaa;
    localparam logic [31:0] UNLOCK_SECOND = 32'h55555555;
    localparam int          MODE_DBG_BIT  = 0;
    localparam int          MODE_LCK_BIT  = 1;
    localparam int          MODE_ACT_BIT  = 2;
    localparam int          MODE_TOF_BIT  = 3;
    localparam int          TRIG_BIT      = 0;
    localparam int          IRQ_OVF_BIT   = 0;
    localparam int          RST_PULSE_CYC = 4;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
endpackage

// File: wdtu_top.sv
// Purpose: Watchdog timer unit with AHB-Lite register slave
// Assumes: Single clock REF_CLK, synchronous active high RST
// Notes:   Chip reset request and cause flag go to reset generation
// What this block does
// R1 - Expiry without retrigger resets the chip
// R2 - 32-bit counter advancing every clock
// R3 - Debug mode expiry raises interrupt instead
// R4 - New reload value engages debug lock
// R5 - Reload writes need unlock pair first
// R6 - Software retriggers before overflow
// R7 - Interrupt output gated by enable bit
// R8 - Clear status write clears overflow flag
// R9 - Enabled debug overflow: only clear retriggers
// R10 - Disabled debug interrupt: trigger write retriggers
// R11 - Counter stalls while clocks are stopped
// R12 - Software retriggers before stopping clocks
// R13 - Watchdog reset acts as external reset
// R14 - Reset cause indication for clock unit
// R15 - No pins beyond registers, irq, reset
// R16 - Reload at 0x04, resets to 0x00ffffff
// R17 - Counter readable at 0x08
// R18 - Status set, clear, view registers
// R19 - Enable set, clear, view registers
// R20 - Mode register four documented bits
// R21 - Trigger bit 0 restarts counting
// R22 - Debug bit settable only while unlocked
// R23 - Load from reload, overflow on wrap
// R24 - Interrupt is AND of status and enable
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdtu_top
    import wdtu_pkg::*;
#(
    parameter int CNT_WIDTH = 32
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic        HREADY,
    input  wire logic [31:0] HWDATA,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        CLK_STOPPED,
    output logic             IRQ,
    output logic             CHIP_RESET_REQ,
    output logic             WDOG_RESET_CAUSE
);
    typedef enum logic [1:0] {WDTU_IDLE, WDTU_FIRST_OK, WDTU_OPEN} wdtu_unlock_e;

    logic [5:0]           addr_q;
    logic                 wr_q;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic [31:0]          reload_q;
    logic                 dbg_q;
    logic                 lock_q;
    logic                 active_q;
    logic                 tof_q;
    logic                 st_q;
    logic                 en_q;
    logic                 hold_q;
    logic                 cause_q;
    logic [2:0]           pulse_q;
    wdtu_unlock_e         unl_q;
    wdtu_unlock_e         unl_d;
    logic [CNT_WIDTH-1:0] count;
    logic                 wrap;
    logic                 addr_ok;
    logic                 take;
    logic                 rd_take;
    logic                 w_mode;
    logic                 w_reload;
    logic                 w_trig;
    logic                 w_stset;
    logic                 w_stclr;
    logic                 w_enset;
    logic                 w_enclr;
    logic                 w_cause;
    logic                 reload_ok;
    logic                 trig_req;
    logic                 retrig;
    logic                 ovf_irq;
    logic                 ovf_rst;
    logic [31:0]          mode_view;
    logic                 rd_hit_mode;
    logic                 rd_hit_reload;
    logic                 rd_hit_count;
    logic                 rd_hit_en;
    logic                 rd_hit_st;
    logic                 rd_hit_cause;
    logic                 st_set_hit;
    logic                 st_clr_hit;
    logic                 en_set_hit;
    logic                 en_clr_hit;
    logic                 cause_clr_hit;
    logic                 trig_ok;
    logic                 clr_restart;

    function automatic logic wr_at(input logic [5:0] a, input logic [5:0] ofs,
                                   input logic wr);
        wr_at = wr && (a == ofs);
    endfunction

    function automatic logic hit_at(input logic [5:0] a, input logic [5:0] ofs);
        hit_at = (a == ofs);
    endfunction

    // Slave always ready with OKAY; reads are zero-wait
    assign addr_ok   = HSEL && HREADY && HTRANS[1];
    assign take      = addr_ok && HWRITE;
    assign rd_take   = addr_ok && !HWRITE;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_q;

    assign w_mode    = wr_at(addr_q, OFS_MODE, wr_q);
    assign w_reload  = wr_at(addr_q, OFS_RELOAD, wr_q);
    assign w_trig    = wr_at(addr_q, OFS_TRIG, wr_q);
    assign w_stset   = wr_at(addr_q, OFS_ST_SET, wr_q);
    assign w_stclr   = wr_at(addr_q, OFS_ST_CLR, wr_q);
    assign w_enset   = wr_at(addr_q, OFS_EN_SET, wr_q);
    assign w_enclr   = wr_at(addr_q, OFS_EN_CLR, wr_q);
    assign w_cause   = wr_at(addr_q, OFS_RSTCAUSE, wr_q);

    // Bit 0 of the data word is the only live bit of the strobes
    assign st_set_hit    = w_stset && HWDATA[IRQ_OVF_BIT];
    assign st_clr_hit    = w_stclr && HWDATA[IRQ_OVF_BIT];
    assign en_set_hit    = w_enset && HWDATA[IRQ_OVF_BIT];
    assign en_clr_hit    = w_enclr && HWDATA[IRQ_OVF_BIT];
    assign cause_clr_hit = w_cause && HWDATA[0];

    // R5 unlock sequence
    always_comb begin
        unl_d = unl_q;
        if (w_reload) begin
            unique case (unl_q)
                WDTU_IDLE:     unl_d = (HWDATA == UNLOCK_FIRST) ? WDTU_FIRST_OK : WDTU_IDLE;
                WDTU_FIRST_OK: unl_d = (HWDATA == UNLOCK_SECOND) ? WDTU_OPEN :
                                       ((HWDATA == UNLOCK_FIRST) ? WDTU_FIRST_OK : WDTU_IDLE);
                WDTU_OPEN:     unl_d = WDTU_IDLE;
                default:       unl_d = WDTU_IDLE;
            endcase
        end
    end
    assign reload_ok = w_reload && (unl_q == WDTU_OPEN);

    // R21 trigger bit
    assign trig_req    = w_trig && HWDATA[TRIG_BIT];
    // R10 trigger works when not held
    assign trig_ok     = trig_req && !hold_q;
    // R9 trigger blocked while held
    // Only clearing the held overflow restarts it
    assign clr_restart = hold_q && st_clr_hit;
    // R6 retrigger restarts period
    assign retrig      = trig_ok || clr_restart;

    // R3 debug expiry is interrupt
    assign ovf_irq  = wrap && dbg_q;
    // R1 expiry resets chip
    assign ovf_rst  = wrap && !dbg_q;

    // R20 mode register view
    assign mode_view = {28'h0000000, tof_q, active_q, lock_q, dbg_q};

    // R16 R17 R18 R19 readback decode
    // Unmapped offsets match no hit and read as zero
    assign rd_hit_mode   = hit_at(HADDR[5:0], OFS_MODE);
    assign rd_hit_reload = hit_at(HADDR[5:0], OFS_RELOAD);
    assign rd_hit_count  = hit_at(HADDR[5:0], OFS_COUNT);
    assign rd_hit_en     = hit_at(HADDR[5:0], OFS_EN_VIEW);
    assign rd_hit_st     = hit_at(HADDR[5:0], OFS_ST_VIEW);
    assign rd_hit_cause  = hit_at(HADDR[5:0], OFS_RSTCAUSE);
    // The counter may be narrower than the bus; upper bits read zero
    assign rdata_d = ({32{rd_hit_mode}}   & mode_view)
                   | ({32{rd_hit_reload}} & reload_q)
                   | ({32{rd_hit_count}}  & 32'(count))
                   | ({32{rd_hit_en}}     & {31'h00000000, en_q})
                   | ({32{rd_hit_st}}     & {31'h00000000, st_q})
                   | ({32{rd_hit_cause}}  & {31'h00000000, cause_q});

    wdtu_counter #(
        .WIDTH(CNT_WIDTH)
    ) u_counter (
        .clk       (REF_CLK),
        .rst       (RST),
        .load      (retrig),
        .load_value(reload_q[CNT_WIDTH-1:0]),
        .run       (active_q),
        .stall     (CLK_STOPPED),
        .count     (count),
        .wrap      (wrap)
    );

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            addr_q <= 6'h00;
            wr_q   <= 1'b0;
        end else begin
            wr_q <= take;
            if (addr_ok) begin
                addr_q <= HADDR[5:0];
            end
        end
    end

    // Read data stands for the data phase only, zero elsewhere
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd_take ? rdata_d : 32'h00000000;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            unl_q <= WDTU_IDLE;
        end else begin
            unl_q <= unl_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            // R16 reload reset value
            reload_q <= RELOAD_RESET;
            lock_q   <= 1'b0;
        end else if (reload_ok) begin
            reload_q <= HWDATA;
            // R4 lock on new reload
            lock_q   <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dbg_q <= 1'b0;
        end else if (w_mode) begin
            // R22 debug set only unlocked
            if (!HWDATA[MODE_DBG_BIT]) begin
                dbg_q <= 1'b0;
            end else if (!lock_q) begin
                dbg_q <= 1'b1;
            end
        end
    end

    // Counter starts on first trigger; a hold suspends it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            active_q <= 1'b0;
        end else if (retrig) begin
            active_q <= 1'b1;
        end else if (ovf_irq && en_q) begin
            active_q <= 1'b0;
        end
    end

    // Hold keeps an unserviced debug overflow from being run over
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            hold_q <= 1'b0;
        end else if (retrig) begin
            hold_q <= 1'b0;
        end else if (ovf_irq && en_q) begin
            hold_q <= 1'b1;
        end
    end

    // Timeout flag is sticky until reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tof_q <= 1'b0;
        end else if (ovf_irq) begin
            tof_q <= 1'b1;
        end
    end

    // R8 clear status; set wins over clear
    // R18 status set and clear
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_q <= 1'b0;
        end else if (ovf_irq || st_set_hit) begin
            st_q <= 1'b1;
        end else if (st_clr_hit) begin
            st_q <= 1'b0;
        end
    end

    // R19 enable set and clear
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            en_q <= 1'b0;
        end else if (en_set_hit) begin
            en_q <= 1'b1;
        end else if (en_clr_hit) begin
            en_q <= 1'b0;
        end
    end

    // R7 R24 gated interrupt output
    assign IRQ = st_q && en_q;

    // R13 chip reset pulse
    // Held several cycles so the reset generator cannot miss it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pulse_q <= 3'h0;
        end else if (ovf_rst) begin
            pulse_q <= 3'(RST_PULSE_CYC);
        end else if (pulse_q != 3'h0) begin
            pulse_q <= pulse_q - 3'h1;
        end
    end
    assign CHIP_RESET_REQ = (pulse_q != 3'h0);

    // R14 reset cause flag
    // Not cleared by RST, since RST follows our own request
    always_ff @(posedge REF_CLK) begin
        if (ovf_rst) begin
            cause_q <= 1'b1;
        end else if (cause_clr_hit) begin
            cause_q <= 1'b0;
        end
    end

    // R15 no pins beyond bus, irq, reset
    assign WDOG_RESET_CAUSE = cause_q;
endmodule // wdtu_top
`default_nettype wire
